// ==== design/srm_pkg.sv ====
// Shared constants and types for the sub-rate port configuration block
package srm_pkg;

    // ****************************************
    // Sizes and clock
    // ****************************************
    localparam int NUM_PORTS = 10;
    localparam int NUM_LINKS = 8;
    localparam int NUM_SEGS = 20;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 24;
    localparam int CLK_KHZ = 100000;

    // ****************************************
    // Clear-to-send delays
    // ****************************************
    localparam int CTS_DLY_A_MS = 30;
    localparam int CTS_DLY_B_MS = 60;
    localparam int CTS_DLY_C_MS = 100;
    localparam int CTS_DLY_A_CYC = CTS_DLY_A_MS * CLK_KHZ;
    localparam int CTS_DLY_B_CYC = CTS_DLY_B_MS * CLK_KHZ;
    localparam int CTS_DLY_C_CYC = CTS_DLY_C_MS * CLK_KHZ;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CFG_A_BASE = 8'h00;
    localparam logic [7:0] CFG_B_BASE = 8'h40;
    localparam logic [7:0] STAT_BASE = 8'h80;
    localparam logic [7:0] LINK_CFG = 8'hc0;
    localparam logic [7:0] LINK_STAT = 8'hc4;

    // ****************************************
    // Configuration word A fields
    // ****************************************
    localparam int A_W = 23;
    localparam int A_ACT = 0;
    localparam int A_WAN_LSB = 1;
    localparam int A_TS_LSB = 4;
    localparam int A_FRAME_LSB = 9;
    localparam int A_RATE_LSB = 12;
    localparam int A_POS_LSB = 16;
    localparam int A_PORT_INTERFACE_TYPE_LSB = 21;
    localparam logic [22:0] A_RESET = 23'h010010;

    // ****************************************
    // Configuration word B fields
    // ****************************************
    localparam int B_W = 14;
    localparam int B_DATA_LSB = 0;
    localparam int B_STOP = 2;
    localparam int B_PAR_LSB = 3;
    localparam int B_CTS_LSB = 6;
    localparam int B_MEC_LSB = 10;
    localparam int B_DLOPT = 13;
    localparam logic [13:0] B_RESET = 14'h0000;
    localparam int B_NA_BIT = 31;
    localparam logic [4:0] PAR_MAX = 5'h04;
    localparam logic [2:0] MEC_MAX = 3'h6;

    // ****************************************
    // Status word fields
    // ****************************************
    localparam int S_ACT = 0;
    localparam int S_LINK = 1;
    localparam int S_CTS = 2;
    localparam int S_RLSD = 3;
    localparam int S_FMT_NA = 4;
    localparam int S_ENG_LSB = 5;
    localparam int S_SEG_LSB = 10;
    localparam logic [4:0] ENGINE_KBPS = 5'h18;

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [2:0] {
        FR_A = 3'h0, FR_B5 = 3'h1, FR_B10 = 3'h2, FR_B20 = 3'h3,
        FR_X50 = 3'h4, FR_ADPCM = 3'h5, FR_HLINK = 3'h6, FR_NLINK = 3'h7
    } srm_frame_t;

    typedef enum logic [3:0] {
        RT_0_3 = 4'h0, RT_1_2 = 4'h1, RT_2_4 = 4'h2, RT_4_8 = 4'h3, RT_9_6 = 4'h4,
        RT_14_4 = 4'h5, RT_19_2 = 4'h6, RT_28_8 = 4'h7, RT_38_4 = 4'h8
    } srm_rate_t;

    typedef enum logic [1:0] {
        IF_ASYN = 2'h0, IF_SYNC = 2'h1, IF_V14 = 2'h2
    } srm_port_interface_type_t;

    typedef enum logic [3:0] {
        CM_PERM = 4'h0, CM_L0 = 4'h1, CM_L30 = 4'h2, CM_L60 = 4'h3, CM_L100 = 4'h4,
        CM_RL0 = 4'h5, CM_RL30 = 4'h6, CM_RL60 = 4'h7, CM_REMOTE_LOCAL_100MS = 4'h8,
        CM_OFF = 4'h9
    } srm_cts_mode_t;

    typedef enum logic [1:0] {
        LS_IDLE = 2'b00, LS_WAIT = 2'b01, LS_ON = 2'b11
    } srm_lead_state_t;

endpackage

// ==== design/srm_port_leads.sv ====
// Modem control lead logic for one port
`timescale 1ns/1ps

module srm_port_leads #(
    parameter logic [23:0] DLY_A_CYC = 24'd3000000,
    parameter logic [23:0] DLY_B_CYC = 24'd6000000,
    parameter logic [23:0] DLY_C_CYC = 24'd10000000
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic port_active,
    input wire logic link_up,
    input wire logic [3:0] cts_mode,
    input wire logic rts,
    input wire logic remote_rts,
    output logic cts,
    output logic rlsd,
    output logic remote_rlsd
);

    typedef struct packed {
        srm_pkg::srm_lead_state_t st;
        logic [23:0] cnt;
        logic cts;
        logic rlsd;
        logic rrlsd;
    } srm_lead_reg_t;

    srm_lead_reg_t st_ff;
    srm_lead_reg_t nxt_st;
    logic [23:0] dly;
    logic rl_mode;
    logic timed;
    logic req;

    // ****************************************
    // Lead sequencing
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        rl_mode = cts_mode >= srm_pkg::CM_RL0 && cts_mode <= srm_pkg::CM_REMOTE_LOCAL_100MS;
        timed = cts_mode >= srm_pkg::CM_L0 && cts_mode <= srm_pkg::CM_REMOTE_LOCAL_100MS;
        case (cts_mode)
            srm_pkg::CM_L30, srm_pkg::CM_RL30: dly = DLY_A_CYC; // [RQ18]
            srm_pkg::CM_L60, srm_pkg::CM_RL60: dly = DLY_B_CYC; // [RQ18]
            srm_pkg::CM_L100, srm_pkg::CM_REMOTE_LOCAL_100MS: dly = DLY_C_CYC; // [RQ18]
            default: dly = 24'h000000;
        endcase
        // Standby drops the request at once
        req = port_active && timed && rts; // [RQ3]
        case (st_ff.st)
            srm_pkg::LS_IDLE: begin
                if (req && dly == 24'h000000) begin
                    nxt_st.st = srm_pkg::LS_ON;
                end else if (req) begin
                    nxt_st.st = srm_pkg::LS_WAIT;
                    nxt_st.cnt = dly - 24'h000001;
                end
            end
            srm_pkg::LS_WAIT: begin
                if (!req) begin
                    nxt_st.st = srm_pkg::LS_IDLE;
                end else if (st_ff.cnt == 24'h000000) begin
                    nxt_st.st = srm_pkg::LS_ON;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 24'h000001;
                end
            end
            srm_pkg::LS_ON: begin
                if (!req) begin
                    nxt_st.st = srm_pkg::LS_IDLE;
                end
            end
            default: nxt_st.st = srm_pkg::LS_IDLE;
        endcase
        case (cts_mode)
            srm_pkg::CM_PERM: nxt_st.cts = port_active; // [RQ14] [RQ3]
            srm_pkg::CM_OFF: nxt_st.cts = 1'b0; // [RQ14]
            default: nxt_st.cts = nxt_st.st == srm_pkg::LS_ON; // [RQ14] [RQ18]
        endcase
        nxt_st.rlsd = port_active && link_up && (rl_mode ? remote_rts : 1'b1); // [RQ2]
        nxt_st.rrlsd = port_active && (rl_mode ? rts : 1'b1); // [RQ18]
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{st: srm_pkg::LS_IDLE, cnt: 24'h000000, default: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cts = st_ff.cts;
    assign rlsd = st_ff.rlsd;
    assign remote_rlsd = st_ff.rrlsd;

endmodule // srm_port_leads

// ==== design/srm_subrate_port_mux.sv ====
// Ten-port sub-rate multiplexer configuration, APB register file and lead control
//
// Notes on behaviour
// [RQ1] Ten ports, each with its own full set of settings.
// [RQ2] Receive detect high or remote RTS when active; low in standby or link down.
// [RQ3] Clear-to-send follows its mode when active; low in standby; standby default.
// [RQ4] Time slot accepted 1-24 on T1 links, 1-31 on E1 links.
// [RQ5] Slot 16 refused on E1 links carrying slot-16 signalling.
// [RQ6] A WAN time slot splits into at most 20 segments of 2.4 kbps.
// [RQ7] Framing caps positions at 1, 5, 10 or 20; single-slot framing default.
// [RQ8] Only twenty-slot framing lets ports of other cards share a slot.
// [RQ9] Speech-engine framing takes a 24 kbps share of the engine.
// [RQ10] Rate from 0.3 to 38.4 kbps in listed steps; 0.3 default.
// [RQ11] Sync ports refuse 0.3, 1.2, 14.4 except 14.4 on engine/link framings.
// [RQ12] Async format: 8/7/6/5 data, 1/2 stop, five parities; 8,1,none default.
// [RQ13] Sync ports report character format as not applicable; it does nothing.
// [RQ14] Clear-to-send mode: permanent, off, local or remote-local with delays.
// [RQ15] Majority correction off or on with threshold 1e-3 to 1e-7 or none.
// [RQ16] Ports map independently to any link and non-contiguous slots.
// [RQ17] Configuring party keeps one slot number from two links off one card.
// [RQ18] Local delays immediate, 30, 60, 100 ms; remote-local drives remote detect.
// [RQ19] Five-slot framing: rates above 9.6 take contiguous positions.
// [RQ20] International framing: 9.6 at n,n+5,n+10,n+15; 4.8 at n,n+10; 2.4 at n.
// [RQ21] Settings held per port and loaded with defaults at bring-up.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module srm_subrate_port_mux #(
    parameter logic [23:0] CTS_DLY_A_CYC = 24'(srm_pkg::CTS_DLY_A_CYC),
    parameter logic [23:0] CTS_DLY_B_CYC = 24'(srm_pkg::CTS_DLY_B_CYC),
    parameter logic [23:0] CTS_DLY_C_CYC = 24'(srm_pkg::CTS_DLY_C_CYC)
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] term_rts,
    input wire logic [9:0] remote_rts,
    input wire logic [7:0] wan_link_up,
    output logic [9:0] term_cts,
    output logic [9:0] term_rlsd,
    output logic [9:0] remote_rlsd,
    output logic [9:0] port_active,
    output logic [9:0] slot_shareable,
    output logic [9:0][19:0] port_seg_mask
);

    localparam int NP = srm_pkg::NUM_PORTS;
    localparam int NL = srm_pkg::NUM_LINKS;

    typedef struct packed {
        logic [NP-1:0][srm_pkg::A_W-1:0] cfg_a;
        logic [NP-1:0][srm_pkg::B_W-1:0] cfg_b;
        logic [NL-1:0] e1;
        logic [NL-1:0] sig16;
        logic [NP-1:0] rts_m;
        logic [NP-1:0] rts_s;
        logic [NP-1:0] rrts_m;
        logic [NP-1:0] rrts_s;
        logic [NL-1:0] lnk_m;
        logic [NL-1:0] lnk_s;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic [NP-1:0] share;
        logic [NP-1:0][19:0] segs;
    } srm_top_reg_t;

    srm_top_reg_t st_ff;
    srm_top_reg_t nxt_st;
    logic [NP-1:0] cts_w;
    logic [NP-1:0] rlsd_w;
    logic [NP-1:0] port_link_up;

    // ****************************************
    // Field helpers
    // ****************************************
    function automatic logic [4:0] ts_of(input logic [22:0] a);
        return a[srm_pkg::A_TS_LSB +: 5];
    endfunction

    function automatic logic [2:0] frame_of(input logic [22:0] a);
        return a[srm_pkg::A_FRAME_LSB +: 3];
    endfunction

    function automatic logic [3:0] rate_of(input logic [22:0] a);
        return a[srm_pkg::A_RATE_LSB +: 4];
    endfunction

    function automatic logic [4:0] pos_of(input logic [22:0] a);
        return a[srm_pkg::A_POS_LSB +: 5];
    endfunction

    function automatic logic is_sync(input logic [22:0] a);
        return a[srm_pkg::A_PORT_INTERFACE_TYPE_LSB +: 2] == srm_pkg::IF_SYNC;
    endfunction

    // Positions a five-slot circuit spans
    function automatic logic [4:0] b5_span(input logic [3:0] rate);
        case (rate)
            srm_pkg::RT_14_4, srm_pkg::RT_19_2: return 5'h02; // [RQ19]
            srm_pkg::RT_28_8: return 5'h03; // [RQ19]
            srm_pkg::RT_38_4: return 5'h04; // [RQ19]
            default: return 5'h01;
        endcase
    endfunction

    // Segments occupied inside the WAN slot
    function automatic logic [19:0] seg_mask(input logic [22:0] a);
        logic [19:0] m;
        int p;
        m = 20'h00000;
        p = int'(pos_of(a)) - 1;
        if (p >= 0 && p < srm_pkg::NUM_SEGS) begin // [RQ6]
            case (frame_of(a))
                srm_pkg::FR_A: m[0] = 1'b1;
                srm_pkg::FR_B5: begin
                    for (int i = 0; i < 4; i++) begin
                        if (i < int'(b5_span(rate_of(a))) && p + i < 5) begin
                            m[p + i] = 1'b1; // [RQ19]
                        end
                    end
                end
                srm_pkg::FR_B10, srm_pkg::FR_B20: m[p] = 1'b1;
                srm_pkg::FR_X50: begin
                    for (int i = 0; i < 4; i++) begin
                        if (p + 5 * i < srm_pkg::NUM_SEGS &&
                            (rate_of(a) == srm_pkg::RT_9_6 ||
                             (rate_of(a) == srm_pkg::RT_4_8 && i[0] == 1'b0) ||
                             i == 0)) begin
                            m[p + 5 * i] = 1'b1; // [RQ20]
                        end
                    end
                end
                default: m = 20'h00000;
            endcase
        end
        return m;
    endfunction

    // Legality of word A apart from slot collisions
    function automatic logic a_ok(input logic [22:0] a, input logic e1, input logic sig16);
        logic ts_ok;
        logic rate_ok;
        logic pos_ok;
        logic [4:0] ts;
        logic [4:0] pos;
        logic [2:0] fr;
        logic [3:0] rt;
        ts = ts_of(a);
        pos = pos_of(a);
        fr = frame_of(a);
        rt = rate_of(a);
        ts_ok = ts != 5'h00 && (e1 ? ts <= 5'h1f : ts <= 5'h18); // [RQ4]
        if (e1 && sig16 && ts == 5'h10) begin
            ts_ok = 1'b0; // [RQ5]
        end
        rate_ok = rt <= srm_pkg::RT_38_4; // [RQ10]
        if (is_sync(a) && (rt == srm_pkg::RT_0_3 || rt == srm_pkg::RT_1_2 ||
            (rt == srm_pkg::RT_14_4 && fr < srm_pkg::FR_ADPCM))) begin
            rate_ok = 1'b0; // [RQ11]
        end
        case (fr)
            srm_pkg::FR_A: pos_ok = pos == 5'h01; // [RQ7]
            srm_pkg::FR_B5: pos_ok = pos != 5'h00 && pos <= 5'h06 - b5_span(rt); // [RQ7] [RQ19]
            srm_pkg::FR_B10: pos_ok = pos != 5'h00 && pos <= 5'h0a; // [RQ7]
            srm_pkg::FR_B20: pos_ok = pos != 5'h00 && pos <= 5'h14; // [RQ7]
            srm_pkg::FR_X50: begin
                case (rt)
                    srm_pkg::RT_2_4: pos_ok = pos != 5'h00 && pos <= 5'h14; // [RQ20]
                    srm_pkg::RT_4_8: pos_ok = pos != 5'h00 && pos <= 5'h0a; // [RQ20]
                    srm_pkg::RT_9_6: pos_ok = pos != 5'h00 && pos <= 5'h05; // [RQ20]
                    default: pos_ok = 1'b0;
                endcase
            end
            default: pos_ok = 1'b1;
        endcase
        return ts_ok && rate_ok && pos_ok && a[srm_pkg::A_PORT_INTERFACE_TYPE_LSB +: 2] != 2'h3;
    endfunction

    function automatic logic b_ok(input logic [13:0] b);
        return {2'h0, b[srm_pkg::B_PAR_LSB +: 3]} <= srm_pkg::PAR_MAX && // [RQ12]
            b[srm_pkg::B_CTS_LSB +: 4] <= srm_pkg::CM_OFF && // [RQ14]
            b[srm_pkg::B_MEC_LSB +: 3] <= srm_pkg::MEC_MAX; // [RQ15]
    endfunction

    // ****************************************
    // APB slave and configuration storage
    // ****************************************
    always_comb begin
        logic [3:0] idx;
        logic [22:0] na;
        logic [2:0] wan;
        logic hit;
        logic err;
        logic [31:0] rd;
        idx = paddr[5:2];
        na = pwdata[srm_pkg::A_W-1:0];
        wan = na[srm_pkg::A_WAN_LSB +: 3];
        hit = 1'b0;
        err = 1'b0;
        rd = 32'h00000000;
        nxt_st = st_ff;
        nxt_st.rts_m = term_rts;
        nxt_st.rts_s = st_ff.rts_m;
        nxt_st.rrts_m = remote_rts;
        nxt_st.rrts_s = st_ff.rrts_m;
        nxt_st.lnk_m = wan_link_up;
        nxt_st.lnk_s = st_ff.lnk_m;
        for (int p = 0; p < NP; p++) begin
            nxt_st.segs[p] = seg_mask(st_ff.cfg_a[p]);
            nxt_st.share[p] = frame_of(st_ff.cfg_a[p]) == srm_pkg::FR_B20; // [RQ8]
        end
        if (psel && !penable) begin
            nxt_st.pready = 1'b1;
            if (paddr[1:0] == 2'b00 && paddr[7:6] != 2'b11 && idx < 4'(NP)) begin
                case (paddr[7:6])
                    2'b00: begin
                        hit = 1'b1;
                        rd = {9'h000, st_ff.cfg_a[idx]};
                        if (pwrite) begin
                            err = !a_ok(na, st_ff.e1[wan], st_ff.sig16[wan]);
                            // Active ports on one link and slot must not collide
                            for (int p = 0; p < NP; p++) begin
                                if (4'(p) != idx && na[srm_pkg::A_ACT] &&
                                    st_ff.cfg_a[p][srm_pkg::A_ACT] &&
                                    st_ff.cfg_a[p][srm_pkg::A_WAN_LSB +: 3] == wan &&
                                    ts_of(st_ff.cfg_a[p]) == ts_of(na) &&
                                    (seg_mask(st_ff.cfg_a[p]) & seg_mask(na)) != 20'h00000) begin
                                    err = 1'b1; // [RQ16]
                                end
                            end
                        end
                    end
                    2'b01: begin
                        hit = 1'b1;
                        if (is_sync(st_ff.cfg_a[idx])) begin
                            rd[srm_pkg::B_NA_BIT] = 1'b1; // [RQ13]
                            rd[srm_pkg::B_CTS_LSB +: 8] = st_ff.cfg_b[idx][srm_pkg::B_CTS_LSB +: 8];
                        end else begin
                            rd[srm_pkg::B_W-1:0] = st_ff.cfg_b[idx]; // [RQ12]
                        end
                        err = pwrite && !b_ok(pwdata[srm_pkg::B_W-1:0]);
                    end
                    2'b10: begin
                        hit = !pwrite;
                        rd[srm_pkg::S_ACT] = st_ff.cfg_a[idx][srm_pkg::A_ACT];
                        rd[srm_pkg::S_LINK] = port_link_up[idx];
                        rd[srm_pkg::S_CTS] = cts_w[idx];
                        rd[srm_pkg::S_RLSD] = rlsd_w[idx];
                        rd[srm_pkg::S_FMT_NA] = is_sync(st_ff.cfg_a[idx]); // [RQ13]
                        if (frame_of(st_ff.cfg_a[idx]) == srm_pkg::FR_ADPCM) begin
                            rd[srm_pkg::S_ENG_LSB +: 5] = srm_pkg::ENGINE_KBPS; // [RQ9]
                        end
                        rd[srm_pkg::S_SEG_LSB +: 20] = st_ff.segs[idx];
                    end
                    default: hit = 1'b0;
                endcase
            end else if (paddr == srm_pkg::LINK_CFG) begin
                hit = 1'b1;
                rd = {16'h0000, st_ff.sig16, st_ff.e1};
            end else if (paddr == srm_pkg::LINK_STAT) begin
                hit = !pwrite;
                rd = {24'h000000, st_ff.lnk_s};
            end
            nxt_st.pslverr = !hit || err;
            nxt_st.prdata = (pwrite || !hit) ? 32'h00000000 : rd;
        end else if (psel && penable && st_ff.pready) begin
            nxt_st.pready = 1'b0;
            nxt_st.pslverr = 1'b0;
            if (pwrite && !st_ff.pslverr) begin
                case (paddr[7:6])
                    2'b00: nxt_st.cfg_a[idx] = na; // [RQ1] [RQ16]
                    2'b01: nxt_st.cfg_b[idx] = pwdata[srm_pkg::B_W-1:0]; // [RQ1]
                    default: begin
                        nxt_st.e1 = pwdata[7:0];
                        nxt_st.sig16 = pwdata[15:8];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            for (int p = 0; p < NP; p++) begin
                st_ff.cfg_a[p] <= srm_pkg::A_RESET; // [RQ21] [RQ3]
                st_ff.cfg_b[p] <= srm_pkg::B_RESET; // [RQ21]
                st_ff.segs[p] <= 20'h00001;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Per-port modem leads
    // ****************************************
    for (genvar g = 0; g < NP; g++) begin : g_port
        assign port_link_up[g] = st_ff.lnk_s[st_ff.cfg_a[g][srm_pkg::A_WAN_LSB +: 3]];
        srm_port_leads #(
            .DLY_A_CYC(CTS_DLY_A_CYC),
            .DLY_B_CYC(CTS_DLY_B_CYC),
            .DLY_C_CYC(CTS_DLY_C_CYC)
        ) u_leads (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .port_active(st_ff.cfg_a[g][srm_pkg::A_ACT]),
            .link_up(port_link_up[g]),
            .cts_mode(st_ff.cfg_b[g][srm_pkg::B_CTS_LSB +: 4]),
            .rts(st_ff.rts_s[g]),
            .remote_rts(st_ff.rrts_s[g]),
            .cts(cts_w[g]),
            .rlsd(rlsd_w[g]),
            .remote_rlsd(remote_rlsd[g])
        );
        assign port_active[g] = st_ff.cfg_a[g][srm_pkg::A_ACT];
    end

    assign term_cts = cts_w;
    assign term_rlsd = rlsd_w;
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign slot_shareable = st_ff.share;
    assign port_seg_mask = st_ff.segs;

endmodule // srm_subrate_port_mux

// ==== dv/srm_far_model.sv ====
// Far-end terminal and WAN link model
`timescale 1ns/1ps

module srm_far_model (
    input wire logic ref_clk,
    input wire logic [2:0] req,
    output logic [9:0] term_rts,
    output logic [9:0] remote_rts,
    output logic [7:0] wan_link_up
);
    always_ff @(posedge ref_clk) begin
        term_rts <= {10{req[0]}};
        remote_rts <= {10{req[1]}};
        wan_link_up <= {8{req[2]}};
    end
endmodule // srm_far_model

// ==== dv/srm_subrate_port_mux_checker.sv ====
// Bus and control lead checks for the sub-rate port block
`timescale 1ns/1ps

module srm_mux_checker #(
    parameter logic [23:0] CTS_DLY_A_CYC = 24'h5,
    parameter logic [23:0] CTS_DLY_B_CYC = 24'ha,
    parameter logic [23:0] CTS_DLY_C_CYC = 24'h14
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] wan_link_up,
    input wire logic [9:0] term_cts,
    input wire logic [9:0] term_rlsd,
    input wire logic [9:0] port_active,
    input wire logic [9:0] slot_shareable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic done;
    assign done = psel && penable && pready && pwrite;
    ans_timing_a: assert property (psel && !penable |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_qual_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    wr_rdata_a: assert property (done |-> prdata == 32'h0) else $error("write data out");
    ro_write_a: assert property (done && paddr[7:6] == 2'h2 |-> pslverr)
        else $error("status write taken");
    act_commit_a: assert property (done && paddr == 8'h00 && !pslverr
        |=> port_active[0] == $past(pwdata[0])) else $error("state not stored");
    share_flag_a: assert property (done && paddr == 8'h00 && !pslverr
        && pwdata[11:9] == 3'h3 |-> ##[1:2] slot_shareable[0]) else $error("share flag");
    link_rlsd_a: assert property (!wan_link_up[0] [*6] |-> !term_rlsd[0])
        else $error("detect with link down");
    standby_lead_a: assert property (!port_active[0] [*5]
        |-> !term_cts[0] && !term_rlsd[0]) else $error("leads in standby");
endmodule // srm_mux_checker

// ==== dv/srm_subrate_port_mux_test.sv ====
// Self-checking bench for the sub-rate port block
`timescale 1ns/1ps

module srm_subrate_port_mux_test;
    logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, wan_link_up;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] req;
    logic [9:0] term_rts, remote_rts, term_cts, term_rlsd, remote_rlsd;
    logic [9:0] port_active, slot_shareable;
    logic [9:0][19:0] port_seg_mask;
    int bad_count, samples_checked;
    srm_subrate_port_mux #(.CTS_DLY_A_CYC(24'h5), .CTS_DLY_B_CYC(24'ha),
        .CTS_DLY_C_CYC(24'h14)) u_dut (.*);
    srm_far_model u_far (.*);
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1, a, d);
        chk("pslverr", {31'h0, e}, {31'h0, err});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk("prdata", e, rd);
    endtask
    task automatic t_reset;
        rdc(8'h00, 32'h00010010);
        rdc(8'h64, 32'h00000000);
        rdc(8'h80, 32'h00000400);
        rdc(8'h24, 32'h00010010);
        $display("test reset done");
    endtask
    task automatic t_refuse;
        wr(8'hc8, 32'h0, 1);
        wr(8'h80, 32'h0, 1);
        wr(8'h00, 32'h00010000, 1);
        wr(8'h00, 32'h00010190, 1);
        wr(8'h00, 32'h00210010, 1);
        wr(8'h00, 32'h00020010, 1);
        wr(8'h00, 32'h00019010, 1);
        wr(8'h00, 32'h001e8210, 1);
        wr(8'h40, 32'h00000028, 1);
        wr(8'h40, 32'h00000280, 1);
        wr(8'h40, 32'h00001c00, 1);
        wr(8'hc0, 32'h00000101, 0);
        wr(8'h00, 32'h00010100, 1);
        wr(8'h00, 32'h000101f0, 0);
        wr(8'hc0, 32'h0, 0);
        wr(8'h00, 32'h00215410, 1);
        wr(8'h00, 32'h00215a10, 0);
        rdc(8'h80, 32'h00000310);
        rdc(8'h40, 32'h80000000);
        $display("test refusals done");
    endtask
    task automatic t_frame;
        wr(8'h04, 32'h00024811, 0);
        w(2);
        chk("seg mask", 32'h10842, {12'h0, port_seg_mask[1]});
        wr(8'h00, 32'h00030610, 0);
        w(2);
        chk("seg mask", 32'h4, {12'h0, port_seg_mask[0]});
        chk("shareable", 32'h1, {31'h0, slot_shareable[0]});
        wr(8'h00, 32'h00038210, 1);
        wr(8'h00, 32'h00018210, 0);
        w(2);
        chk("seg mask", 32'hf, {12'h0, port_seg_mask[0]});
        $display("test framing done");
    endtask
    task automatic leads(input logic [2:0] r, input int n, input logic [2:0] e);
        req <= r;
        w(n);
        chk("leads", {29'h0, e}, {29'h0, term_cts[0], term_rlsd[0], remote_rlsd[0]});
    endtask
    task automatic t_leads;
        wr(8'h40, 32'h0, 0);
        wr(8'h00, 32'h00010011, 0);
        leads(3'h4, 6, 3'h7);
        leads(3'h0, 8, 3'h5);
        wr(8'h00, 32'h00010010, 0);
        leads(3'h4, 6, 3'h0);
        wr(8'h40, 32'h00000080, 0);
        wr(8'h00, 32'h00010011, 0);
        leads(3'h5, 3, 3'h3);
        leads(3'h5, 12, 3'h7);
        wr(8'h40, 32'h00000240, 0);
        leads(3'h5, 6, 3'h3);
        wr(8'h40, 32'h00000140, 0);
        leads(3'h5, 8, 3'h5);
        leads(3'h7, 8, 3'h7);
        $display("test leads done");
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, req} = '0;
        w(6);
        arst_n <= 1;
        w(1);
        t_reset();
        t_refuse();
        t_frame();
        t_leads();
        print_verdict();
    end
    initial begin
        w(20000);
        bad_count++;
        print_verdict();
    end
endmodule // srm_subrate_port_mux_test

bind srm_subrate_port_mux srm_mux_checker #(.CTS_DLY_A_CYC(CTS_DLY_A_CYC),
    .CTS_DLY_B_CYC(CTS_DLY_B_CYC), .CTS_DLY_C_CYC(CTS_DLY_C_CYC)) u_chk (.*);
